// ==== include/asdc_pkg.sv ====
// ------------------------------------------------------------
// Register map, fields and types
// ------------------------------------------------------------
package asdc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [15:0] ADR_DLY_CFG = 16'h0008;
  localparam logic [15:0] ADR_MGAIN_LO = 16'h001b;
  localparam logic [15:0] ADR_MGAIN_OFS = 16'h001c;
  localparam logic [15:0] ADR_AGAIN_LO = 16'h001d;
  localparam logic [15:0] ADR_AGAIN_OFS = 16'h001e;
  localparam logic [15:0] ADR_CTRL = 16'h0040;
  localparam logic [15:0] ADR_STAT = 16'h0041;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Field layout
  localparam int DLY_W = 6;
  localparam int DLY_LSB = 0;
  localparam int GAIN_W = 9;
  localparam int GAIN_LO_W = 8;
  localparam int GAIN_TOP_BIT = 7;
  localparam int OFS_W = 7;
  localparam int OFS_LSB = 0;
  localparam int GAIN_FRAC = 15;
  localparam int CTRL_GO_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LOADED_BIT = 1;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DLY_STEP_US = 5;
  localparam int DLY_MAX_US = 200;
  localparam int DLY_STEP_NS = DLY_STEP_US * 1000;
  localparam int DLY_STEP_CYC = DLY_STEP_NS / CLK_PERIOD_NS;
  localparam logic [5:0] DLY_MAX_CODE = 6'(DLY_MAX_US / DLY_STEP_US);
  // Types
  typedef struct packed {
    logic [GAIN_W-1:0] gain;
    logic [OFS_W-1:0] offset;
  } asdc_trim_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } asdc_bus_req_t;
  typedef enum logic {TMR_IDLE, TMR_WAIT} asdc_tmr_st_t;
  typedef enum logic {LD_WAIT, LD_DONE} asdc_ld_st_t;
endpackage

// ==== logic/asdc_start_timer.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// Start delay timer
// ------------------------------------------------------------
module asdc_start_timer #(
  parameter int STEP_CYC = asdc_pkg::DLY_STEP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_go,
  input wire logic [5:0] i_code,
  output logic o_busy,
  output logic o_start
);
  localparam int STEP_W = $clog2(STEP_CYC + 1);
  localparam logic [STEP_W-1:0] STEP_RLD = STEP_W'(STEP_CYC - 1);

  typedef struct packed {
    asdc_pkg::asdc_tmr_st_t st;
    logic [STEP_W-1:0] step;
    logic [5:0] left;
    logic start;
  } asdc_tmr_state_t;

  asdc_tmr_state_t s_q, s_d;
  logic [5:0] eff_code;

  // Out-of-range codes mean no wait
  assign eff_code = (i_code > asdc_pkg::DLY_MAX_CODE) ? 6'h00 : i_code;

  // Counts code steps of one step period each
  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    case (s_q.st)
      asdc_pkg::TMR_IDLE: begin
        // Go while waiting is dropped, not queued
        if (i_go) begin
          if (eff_code == 6'h00) begin
            s_d.start = 1'b1;
          end else begin
            s_d.st = asdc_pkg::TMR_WAIT;
            s_d.left = eff_code;
            s_d.step = STEP_RLD;
          end
        end
      end
      asdc_pkg::TMR_WAIT: begin
        if (s_q.step == '0) begin
          if (s_q.left == 6'h01) begin
            s_d.start = 1'b1;
            s_d.st = asdc_pkg::TMR_IDLE;
          end else begin
            s_d.left = s_q.left - 6'h01;
            s_d.step = STEP_RLD;
          end
        end else begin
          s_d.step = s_q.step - STEP_W'(1);
        end
      end
      default: s_d.st = asdc_pkg::TMR_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '{asdc_pkg::TMR_IDLE, '0, 6'h00, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_busy = (s_q.st == asdc_pkg::TMR_WAIT);
  assign o_start = s_q.start;
endmodule // asdc_start_timer

// ==== logic/asdc_top.sv ====
// Operation
// - Go bit write delays enabling main and current-sense converters by programmed delay.
// - Six-bit delay code selects 0 to 200 us in 5 us steps.
// - Codes beyond the range mean zero delay.
// - Main gain trim is nine bits: low byte plus one top bit.
// - Main gain top bit sits in bit 7 beside the main offset.
// - Each reset copies stored gain trims from OTP into gain registers.
// - Each reset copies stored offset trims from OTP into offset fields.
// - Trims are applied automatically to every raw conversion result.
// - Main offset trim is seven bits in bits 6 to 0.
// - Aux gain low byte fills a whole register, same range as main.
// - Aux gain top bit in bit 7 of next register, beside aux offset.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
module asdc_top #(
  parameter int DLY_STEP_CYCLES = asdc_pkg::DLY_STEP_CYC,
  parameter int RAW_W = 16,
  parameter int OFS_SHL = 0
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire asdc_pkg::asdc_bus_req_t i_bus,
  output logic [asdc_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_otp_vld,
  input wire asdc_pkg::asdc_trim_t i_otp_main,
  input wire asdc_pkg::asdc_trim_t i_otp_aux,
  input wire logic [RAW_W-1:0] i_main_raw,
  input wire logic i_main_raw_vld,
  input wire logic [RAW_W-1:0] i_aux_raw,
  input wire logic i_aux_raw_vld,
  output logic o_main_cs_start,
  output logic o_dly_busy,
  output logic o_trim_loaded,
  output asdc_pkg::asdc_trim_t o_main_trim,
  output asdc_pkg::asdc_trim_t o_aux_trim,
  output logic [RAW_W-1:0] o_main_res,
  output logic o_main_res_vld,
  output logic [RAW_W-1:0] o_aux_res,
  output logic o_aux_res_vld
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dly_cfg;
    logic [7:0] mgain_lo;
    logic [7:0] mgain_ofs;
    logic [7:0] again_lo;
    logic [7:0] again_ofs;
    logic [7:0] rdata;
    asdc_pkg::asdc_ld_st_t ld_st;
  } asdc_top_state_t;

  asdc_top_state_t s_q, s_d;
  logic wr_hit_ctrl;
  logic go;
  logic tmr_busy;
  logic tmr_start;
  logic [7:0] stat_byte;
  logic [7:0] rd_mux;
  asdc_pkg::asdc_trim_t main_trim;
  asdc_pkg::asdc_trim_t aux_trim;

  // ------------------------------------------------------------
  // Go command decode
  // ------------------------------------------------------------
  // Self-clearing: the go bit is never stored
  assign wr_hit_ctrl = i_bus.wr && (i_bus.addr == asdc_pkg::ADR_CTRL);
  assign go = wr_hit_ctrl && i_bus.wdata[asdc_pkg::CTRL_GO_BIT];

  // ------------------------------------------------------------
  // Trim assembly
  // ------------------------------------------------------------
  // Top bit joins the low byte to form nine-bit gains
  assign main_trim.gain = {s_q.mgain_ofs[asdc_pkg::GAIN_TOP_BIT],
    s_q.mgain_lo};
  assign main_trim.offset =
    s_q.mgain_ofs[asdc_pkg::OFS_LSB +: asdc_pkg::OFS_W];
  assign aux_trim.gain = {s_q.again_ofs[asdc_pkg::GAIN_TOP_BIT],
    s_q.again_lo};
  assign aux_trim.offset =
    s_q.again_ofs[asdc_pkg::OFS_LSB +: asdc_pkg::OFS_W];

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Status byte: timer busy and trim load done
  always_comb begin
    stat_byte = 8'h00;
    stat_byte[asdc_pkg::STAT_BUSY_BIT] = tmr_busy;
    stat_byte[asdc_pkg::STAT_LOADED_BIT] = (s_q.ld_st == asdc_pkg::LD_DONE);
  end

  // Unmapped and control addresses read as zero
  always_comb begin
    case (i_bus.addr)
      asdc_pkg::ADR_DLY_CFG: rd_mux = s_q.dly_cfg;
      asdc_pkg::ADR_MGAIN_LO: rd_mux = s_q.mgain_lo;
      asdc_pkg::ADR_MGAIN_OFS: rd_mux = s_q.mgain_ofs;
      asdc_pkg::ADR_AGAIN_LO: rd_mux = s_q.again_lo;
      asdc_pkg::ADR_AGAIN_OFS: rd_mux = s_q.again_ofs;
      asdc_pkg::ADR_STAT: rd_mux = stat_byte;
      default: rd_mux = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Read data live one cycle only, zero otherwise
    s_d.rdata = i_bus.rd ? rd_mux : 8'h00;
    // Host writes to the register bank
    if (i_bus.wr) begin
      case (i_bus.addr)
        asdc_pkg::ADR_DLY_CFG: s_d.dly_cfg = i_bus.wdata;
        asdc_pkg::ADR_MGAIN_LO: s_d.mgain_lo = i_bus.wdata;
        asdc_pkg::ADR_MGAIN_OFS: s_d.mgain_ofs = i_bus.wdata;
        asdc_pkg::ADR_AGAIN_LO: s_d.again_lo = i_bus.wdata;
        asdc_pkg::ADR_AGAIN_OFS: s_d.again_ofs = i_bus.wdata;
        default: s_d.dly_cfg = s_q.dly_cfg;
      endcase
    end
    // OTP copy after reset; it overrides a host write in the same cycle
    case (s_q.ld_st)
      asdc_pkg::LD_WAIT: begin
        if (i_otp_vld) begin
          s_d.mgain_lo = i_otp_main.gain[asdc_pkg::GAIN_LO_W-1:0];
          s_d.again_lo = i_otp_aux.gain[asdc_pkg::GAIN_LO_W-1:0];
          s_d.mgain_ofs = {i_otp_main.gain[asdc_pkg::GAIN_LO_W],
            i_otp_main.offset};
          s_d.again_ofs = {i_otp_aux.gain[asdc_pkg::GAIN_LO_W],
            i_otp_aux.offset};
          s_d.ld_st = asdc_pkg::LD_DONE;
        end
      end
      asdc_pkg::LD_DONE: s_d.ld_st = asdc_pkg::LD_DONE;
      default: s_d.ld_st = asdc_pkg::LD_WAIT;
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Zero reset means no correction until OTP arrives
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '{asdc_pkg::RST_BYTE, asdc_pkg::RST_BYTE, asdc_pkg::RST_BYTE,
        asdc_pkg::RST_BYTE, asdc_pkg::RST_BYTE, asdc_pkg::RST_BYTE,
        asdc_pkg::LD_WAIT};
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Start delay timer
  // ------------------------------------------------------------
  // Shared by main and current-sense converters
  asdc_start_timer #(
    .STEP_CYC(DLY_STEP_CYCLES)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_go(go),
    .i_code(s_q.dly_cfg[asdc_pkg::DLY_LSB +: asdc_pkg::DLY_W]),
    .o_busy(tmr_busy),
    .o_start(tmr_start)
  );

  // ------------------------------------------------------------
  // Result correction
  // ------------------------------------------------------------
  // Corrections follow live register contents
  asdc_trim_corr #(
    .RAW_W(RAW_W),
    .OFS_SHL(OFS_SHL)
  ) u_main_corr (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_raw(i_main_raw),
    .i_vld(i_main_raw_vld),
    .i_trim(main_trim),
    .o_res(o_main_res),
    .o_vld(o_main_res_vld)
  );

  asdc_trim_corr #(
    .RAW_W(RAW_W),
    .OFS_SHL(OFS_SHL)
  ) u_aux_corr (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_raw(i_aux_raw),
    .i_vld(i_aux_raw_vld),
    .i_trim(aux_trim),
    .o_res(o_aux_res),
    .o_vld(o_aux_res_vld)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_rdata = s_q.rdata;
  assign o_main_cs_start = tmr_start;
  assign o_dly_busy = tmr_busy;
  assign o_trim_loaded = (s_q.ld_st == asdc_pkg::LD_DONE);
  assign o_main_trim = main_trim;
  assign o_aux_trim = aux_trim;
endmodule // asdc_top

// ==== logic/asdc_trim_corr.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// Gain and offset correction of one result stream
// ------------------------------------------------------------
module asdc_trim_corr #(
  parameter int RAW_W = 16,
  parameter int OFS_SHL = 0
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [RAW_W-1:0] i_raw,
  input wire logic i_vld,
  input wire asdc_pkg::asdc_trim_t i_trim,
  output logic [RAW_W-1:0] o_res,
  output logic o_vld
);
  localparam int PW = RAW_W + asdc_pkg::GAIN_W + 2;
  localparam logic signed [PW-1:0] MAXV = PW'((2 ** (RAW_W - 1)) - 1);
  localparam logic signed [PW-1:0] MINV = -MAXV - PW'(1);

  typedef struct packed {
    logic [RAW_W-1:0] res;
    logic vld;
  } asdc_corr_state_t;

  asdc_corr_state_t s_q, s_d;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] sum;

  // Signed trims, so zero trims pass raw unchanged
  always_comb begin
    prod = $signed(i_raw) * $signed(i_trim.gain);
    sum = $signed(i_raw) + (prod >>> asdc_pkg::GAIN_FRAC)
      + ($signed(i_trim.offset) <<< OFS_SHL);
    s_d.vld = i_vld;
    s_d.res = s_q.res;
    // Saturate rather than wrap at full scale
    if (i_vld) begin
      if (sum > MAXV) begin
        s_d.res = MAXV[RAW_W-1:0];
      end else if (sum < MINV) begin
        s_d.res = MINV[RAW_W-1:0];
      end else begin
        s_d.res = sum[RAW_W-1:0];
      end
    end
  end

  // Result register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_res = s_q.res;
  assign o_vld = s_q.vld;
endmodule // asdc_trim_corr

// ==== test/asdc_top_monitor.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// Port checker for the trim and delay slice
// ----------------------------------------
module asdc_top_monitor #(
  parameter int RAW_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire asdc_pkg::asdc_bus_req_t i_bus,
  input wire logic [asdc_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_otp_vld,
  input wire asdc_pkg::asdc_trim_t i_otp_main,
  input wire asdc_pkg::asdc_trim_t i_otp_aux,
  input wire logic [RAW_W-1:0] i_main_raw,
  input wire logic i_main_raw_vld,
  input wire logic i_aux_raw_vld,
  input wire logic o_main_cs_start,
  input wire logic o_dly_busy,
  input wire logic o_trim_loaded,
  input wire asdc_pkg::asdc_trim_t o_main_trim,
  input wire asdc_pkg::asdc_trim_t o_aux_trim,
  input wire logic [RAW_W-1:0] o_main_res,
  input wire logic o_main_res_vld,
  input wire logic o_aux_res_vld
);
  logic [7:0] main_top;
  logic [7:0] main_lo;
  // Register images as software should read them
  assign main_top = {o_main_trim.gain[8], o_main_trim.offset};
  assign main_lo = o_main_trim.gain[7:0];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  property p_start_pulse; o_main_cs_start |=> !o_main_cs_start; endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse longer than one cycle");
  property p_busy_end; $fell(o_dly_busy) |-> o_main_cs_start; endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("delay ended without start");
  property p_otp_copy;
    i_otp_vld && !o_trim_loaded |=> o_trim_loaded && o_main_trim == $past(i_otp_main)
      && o_aux_trim == $past(i_otp_aux);
  endproperty
  a_otp_copy: assert property (p_otp_copy)
    else $error("stored trims not copied");
  property p_main_vld; i_main_raw_vld |=> o_main_res_vld; endproperty
  a_main_vld: assert property (p_main_vld)
    else $error("main result not corrected");
  property p_aux_vld; i_aux_raw_vld |=> o_aux_res_vld; endproperty
  a_aux_vld: assert property (p_aux_vld)
    else $error("aux result not corrected");
  property p_zero_trim;
    i_main_raw_vld && o_main_trim == 16'h0000 |=> o_main_res == $past(i_main_raw);
  endproperty
  a_zero_trim: assert property (p_zero_trim)
    else $error("zero trim altered result");
  property p_rd_top;
    i_bus.rd && i_bus.addr == asdc_pkg::ADR_MGAIN_OFS |=> o_rdata == $past(main_top);
  endproperty
  a_rd_top: assert property (p_rd_top)
    else $error("gain top and offset read wrong");
  property p_rd_lo;
    i_bus.rd && i_bus.addr == asdc_pkg::ADR_MGAIN_LO |=> o_rdata == $past(main_lo);
  endproperty
  a_rd_lo: assert property (p_rd_lo)
    else $error("gain low byte read wrong");
endmodule // asdc_top_monitor

bind asdc_top asdc_top_monitor #(.RAW_W(RAW_W)) u_mon (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_otp_vld(i_otp_vld), .i_otp_main(i_otp_main), .i_otp_aux(i_otp_aux),
  .i_main_raw(i_main_raw), .i_main_raw_vld(i_main_raw_vld), .i_aux_raw_vld(i_aux_raw_vld),
  .o_main_cs_start(o_main_cs_start), .o_dly_busy(o_dly_busy), .o_trim_loaded(o_trim_loaded),
  .o_main_trim(o_main_trim), .o_aux_trim(o_aux_trim), .o_main_res(o_main_res),
  .o_main_res_vld(o_main_res_vld), .o_aux_res_vld(o_aux_res_vld));

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// Register and timing bench
// ----------------------------------------
module tb_top;
  localparam int STEP = 2;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  asdc_pkg::asdc_bus_req_t bus = '0;
  logic otp_vld = 1'b0;
  asdc_pkg::asdc_trim_t otp_m = 16'h0000;
  asdc_pkg::asdc_trim_t otp_a = 16'h0000;
  logic [15:0] m_raw = 16'h0000;
  logic [15:0] a_raw = 16'h0000;
  logic m_vld = 1'b0;
  logic a_vld = 1'b0;
  logic [7:0] rdata;
  logic start;
  logic busy;
  logic loaded;
  asdc_pkg::asdc_trim_t m_trim;
  asdc_pkg::asdc_trim_t a_trim;
  logic [15:0] m_res;
  logic [15:0] a_res;
  logic m_rv;
  logic a_rv;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  logic [15:0] adrs [7] = '{16'h0008, 16'h001b, 16'h001c, 16'h001d, 16'h001e, 16'h0040,
    16'h0055};
  logic [31:0] cases [5] = '{32'h0000_1234, 32'h8000_4000, 32'h7fff_c000, 32'h003f_7ff0,
    32'h0040_8010};
  logic [5:0] codes [6] = '{6'h00, 6'h01, 6'h07, 6'h28, 6'h29, 6'h3f};

  // Short step keeps the longest delay code to about eighty cycles
  asdc_top #(.DLY_STEP_CYCLES(STEP)) u_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus(bus), .o_rdata(rdata), .i_otp_vld(otp_vld),
    .i_otp_main(otp_m), .i_otp_aux(otp_a), .i_main_raw(m_raw), .i_main_raw_vld(m_vld),
    .i_aux_raw(a_raw), .i_aux_raw_vld(a_vld), .o_main_cs_start(start), .o_dly_busy(busy),
    .o_trim_loaded(loaded), .o_main_trim(m_trim), .o_aux_trim(a_trim), .o_main_res(m_res),
    .o_main_res_vld(m_rv), .o_aux_res(a_res), .o_aux_res_vld(a_rv));

  always #5 i_clk = ~i_clk;

  // Hang guard, well above the longest delay walk
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus <= '0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus <= '0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask

  task automatic wait_start();
    while (start !== 1'b1 && n < 500) begin
      @(posedge i_clk);
      #1;
      n++;
    end
  endtask

  // Reference correction, saturating to the signed result range
  function automatic logic [15:0] corr(logic [15:0] r, logic [8:0] g, logic [6:0] o);
    longint v;
    v = longint'($signed(r)) + ((longint'($signed(r)) * longint'($signed(g))) >>> 15);
    v = v + longint'($signed(o));
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    foreach (adrs[i]) rchk(adrs[i], 8'h00);
    // Nothing copied before the stored trims are offered
    chk({15'h0000, loaded}, 16'h0000);
    $display("reset values done");
    @(posedge i_clk);
    otp_m <= {9'h1a5, 7'h3c};
    otp_a <= {9'h0c3, 7'h45};
    otp_vld <= 1'b1;
    rchk(16'h001b, 8'ha5);
    rchk(16'h001c, 8'hbc);
    rchk(16'h001d, 8'hc3);
    rchk(16'h001e, 8'h45);
    rchk(16'h0041, 8'h02);
    chk({15'h0000, loaded}, 16'h0001);
    $display("trim load done");
    foreach (codes[i]) begin
      wr(16'h0008, {2'b10, codes[i]});
      rchk(16'h0008, {2'b10, codes[i]});
      wr(16'h0040, 8'h01);
      n = 1;
      #1;
      // Zero and undefined codes start at once, so no busy cycle
      if (codes[i] != 6'h00 && codes[i] <= 6'h28) begin
        chk({15'h0000, busy}, 16'h0001);
      end else begin
        chk({15'h0000, busy}, 16'h0000);
      end
      wait_start();
      chk(16'(n), 16'(1 + ((codes[i] > 6'h28) ? 0 : int'(codes[i])) * STEP));
    end
    // Second go inside the wait must not restart the count
    wr(16'h0008, 8'h03);
    wr(16'h0040, 8'h01);
    wr(16'h0040, 8'h01);
    n = 3;
    #1;
    wait_start();
    chk(16'(n), 16'(1 + 3 * STEP));
    wr(16'h0055, 8'hff);
    rchk(16'h0055, 8'h00);
    $display("start delay done");
    foreach (cases[i]) begin
      wr(16'h001b, cases[i][23:16]);
      wr(16'h001c, {cases[i][24], cases[i][22:16]});
      wr(16'h001d, cases[i][23:16]);
      wr(16'h001e, {cases[i][24], cases[i][22:16]});
      @(posedge i_clk);
      m_raw <= cases[i][15:0];
      a_raw <= cases[i][15:0];
      m_vld <= 1'b1;
      a_vld <= 1'b1;
      @(posedge i_clk);
      m_vld <= 1'b0;
      a_vld <= 1'b0;
      #1;
      chk(m_trim, {cases[i][24:16], cases[i][22:16]});
      chk(a_trim, {cases[i][24:16], cases[i][22:16]});
      chk(m_res, corr(cases[i][15:0], cases[i][24:16], cases[i][22:16]));
      chk(a_res, corr(cases[i][15:0], cases[i][24:16], cases[i][22:16]));
      chk({14'h0000, m_rv, a_rv}, 16'h0003);
    end
    $display("correction done");
    // Reset is driven on the edge like every other input
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    #1;
    chk({15'h0000, loaded}, 16'h0000);
    rchk(16'h001b, 8'ha5);
    rchk(16'h001c, 8'hbc);
    rchk(16'h0008, 8'h00);
    chk({15'h0000, loaded}, 16'h0001);
    $display("second reset done");
    summarize();
  end
endmodule // tb_top
